//--- bench/led_pwm_bus_address_decoder_test.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH %0t got %h want %h", $time, a, e); end end
module led_pwm_bus_address_decoder_test;
  logic clock, rstn, scl, drv, sda, sda_out, sda_oe, oen, auto_inc, ack, k;
  logic wr_strobe, soft_reset;
  logic [5:0] strap;
  logic [15:0] led, pwm;
  logic [7:0] rd, reg_ptr, wr_addr, wr_data, st_addr, st_data, own, p, d, q;
  logic [7:0] tbl [8] = '{8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE8, 8'hE9};
  int failures = 0;
  int checks = 0;
  int n_sr = 0;
  // pulled-up line: low if either side pulls
  assign sda = !drv && (sda_oe ? sda_out : 1'b1);
  lpad_bus_master u_m (.clk(clock), .sda(sda), .scl(scl), .drv(drv));
  lpad_top u_dut (
    .CLOCK(clock), .RSTN(rstn), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .STRAP_ADDR_BIT_0(strap[0]), .STRAP_ADDR_BIT_1(strap[1]), .STRAP_ADDR_BIT_2(strap[2]),
    .STRAP_ADDR_BIT_3(strap[3]), .STRAP_ADDR_BIT_4(strap[4]), .STRAP_ADDR_BIT_5(strap[5]),
    .OUTPUT_ENABLE_N(oen), .AUTO_INC(auto_inc), .LED_LEVEL(led), .RD_DATA(rd),
    .PWM_OUTPUT_N(pwm), .REG_PTR(reg_ptr), .WR_ADDR(wr_addr), .WR_DATA(wr_data),
    .WR_STROBE(wr_strobe), .SOFT_RESET(soft_reset)
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (wr_strobe === 1'b1) begin
      st_addr <= wr_addr;
      st_data <= wr_data;
    end
    if (soft_reset === 1'b1) n_sr <= n_sr + 1;
  end
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h00: return 8'h01;
      8'h02: return 8'hE2;
      8'h03: return 8'hE4;
      8'h04: return 8'hE8;
      8'h05: return 8'hE0;
      default: return rd;
    endcase
  endfunction
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic go(input logic [7:0] a);
    u_m.start();
    u_m.wr(a, ack);
  endtask
  task automatic rd_two(input logic [7:0] x);
    logic [7:0] v;
    @(posedge clock) auto_inc <= 1'b1;
    go(own);
    u_m.wr(x, k);
    u_m.stop();
    go(own | 8'h01);
    `CHK(ack, 1'b1)
    u_m.rd(1'b0, v);
    `CHK(v, exp_rd(x))
    u_m.rd(1'b1, v);
    `CHK(v, exp_rd(x + 8'h01))
    u_m.stop();
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    failures++;
    close_out();
  end
  initial begin
    rstn = 1'b0;
    strap = 6'h00;
    oen = 1'b0;
    auto_inc = 1'b0;
    led = 16'h0000;
    rd = 8'h00;
    void'($urandom(59));
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    rd <= 8'($urandom);
    repeat (10) @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      // own address kept off broadcast and general call
      strap <= i == 0 ? 6'h38 : {1'b0, 5'($urandom)};
      auto_inc <= 1'($urandom);
      p = 8'h10 + 8'($urandom % 200);
      d = 8'($urandom);
      q = 8'($urandom);
      repeat (8) @(posedge clock);
      own = {1'b1, strap, 1'b0};
      go(own ^ 8'h02);
      `CHK(ack, 1'b0)
      u_m.stop();
      go(own);
      `CHK(ack, 1'b1)
      u_m.wr(p, k);
      `CHK(reg_ptr, p)
      u_m.wr(d, k);
      `CHK({st_addr, st_data}, {p, d})
      u_m.wr(q, k);
      `CHK({st_addr, st_data}, {p + 8'(auto_inc), q})
      u_m.stop();
    end
    $display("test own_write done");
    for (int x = 0; x < 5; x += 2) rd_two(8'(x));
    $display("test default_read done");
    for (int i = 0; i < 8; i++) begin
      go(tbl[i]);
      `CHK(ack, tbl[i] < 8'hE2)
      if (ack === 1'b1 && tbl[i][0]) u_m.rd(1'b1, q);
      u_m.stop();
    end
    $display("test group_table done");
    go(own);
    u_m.wr(8'h02, k);
    u_m.wr(8'hC4, k);
    u_m.stop();
    go(own);
    u_m.wr(8'h00, k);
    u_m.wr(8'h09, k);
    u_m.stop();
    go(8'hC4);
    `CHK(ack, 1'b1)
    u_m.stop();
    go(own);
    u_m.wr(8'h05, k);
    u_m.wr(8'hD2, k);
    u_m.stop();
    go(8'hD2);
    `CHK(ack, 1'b1)
    u_m.stop();
    go(8'hE0);
    `CHK(ack, 1'b0)
    u_m.stop();
    go(8'h01);
    `CHK(ack, 1'b0)
    u_m.stop();
    go(8'h00);
    u_m.wr(8'h07, k);
    `CHK({k, n_sr == 0}, 2'b01)
    u_m.stop();
    go(8'h00);
    `CHK(ack, 1'b1)
    u_m.wr(8'h06, k);
    u_m.stop();
    `CHK(n_sr == 1, 1'b1)
    go(8'hC4);
    `CHK(ack, 1'b0)
    u_m.stop();
    go(8'hE0);
    `CHK(ack, 1'b1)
    u_m.stop();
    rd_two(8'h02);
    $display("test soft_reset done");
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      led <= 16'($urandom);
      oen <= i[0];
      repeat (8) @(posedge clock);
      `CHK(pwm, oen ? 16'h0000 : led)
    end
    $display("test output_enable done");
    close_out();
  end
endmodule

//--- bench/lpad_bus_master.sv
`timescale 1ns/1ns
module lpad_bus_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic drv
);
  // half bit in cycles; covers the 4-5 cycle input lag
  localparam int H = 10;
  initial begin
    scl = 1'b1;
    drv = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start();
    drv <= 1'b0;
    tick(H / 2);
    scl <= 1'b1;
    tick(H / 2);
    drv <= 1'b1;
    tick(H / 2);
    scl <= 1'b0;
    tick(H / 2);
  endtask
  task automatic bit_io(input logic b, output logic r);
    drv <= !b;
    tick(H / 2);
    scl <= 1'b1;
    tick(H);
    r = sda;
    scl <= 1'b0;
    tick(H / 2);
  endtask
  // msb first, ninth bit is the ack
  task automatic wr(input logic [7:0] v, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    a = !r;
  endtask
  task automatic rd(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(last, r);
  endtask
  task automatic stop();
    drv <= 1'b1;
    tick(H / 2);
    scl <= 1'b1;
    tick(H / 2);
    drv <= 1'b0;
    tick(H);
  endtask
endmodule

//--- bench/lpad_checker.sv
`timescale 1ns/1ns
module lpad_checker (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic SCL,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic [15:0] LED_LEVEL,
  input wire logic [15:0] PWM_OUTPUT_N,
  input wire logic [7:0] REG_PTR,
  input wire logic WR_STROBE,
  input wire logic SOFT_RESET
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // ****
  // port relations
  // ****
  a_strobe_one_cycle: assert property (WR_STROBE |=> !WR_STROBE)
    else $error("write strobe too wide");
  a_soft_one_cycle: assert property (SOFT_RESET |=> !SOFT_RESET)
    else $error("soft reset pulse too wide");
  a_soft_leds_dark: assert property (SOFT_RESET |-> ##[0:1] PWM_OUTPUT_N == 16'h0000)
    else $error("leds not low on soft reset");
  a_soft_ptr_clear: assert property (SOFT_RESET |-> ##[0:2] REG_PTR == 8'h00)
    else $error("pointer kept over soft reset");
  a_oe_gates_leds: assert property (OUTPUT_ENABLE_N [*6] |-> PWM_OUTPUT_N == 16'h0000)
    else $error("leds lit while disabled");
  a_leds_follow: assert property ((!OUTPUT_ENABLE_N && !SOFT_RESET) [*6]
    |-> PWM_OUTPUT_N == $past(LED_LEVEL))
    else $error("leds do not follow level");
  a_ack_edge_low: assert property ($changed(SDA_OE) |-> !SCL)
    else $error("data line moved with clock high");
  a_drain_only: assert property (SDA_OUT == 1'b0)
    else $error("data line driven high");
  a_strobe_clock_low: assert property (WR_STROBE || SOFT_RESET |-> !SCL)
    else $error("byte taken with clock high");
endmodule

bind lpad_top lpad_checker u_chk (
  .CLOCK(CLOCK),
  .RSTN(RSTN),
  .SCL(SCL),
  .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE),
  .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
  .LED_LEVEL(LED_LEVEL),
  .PWM_OUTPUT_N(PWM_OUTPUT_N),
  .REG_PTR(REG_PTR),
  .WR_STROBE(WR_STROBE),
  .SOFT_RESET(SOFT_RESET)
);

//--- src/lpad_pkg.sv
// How it works
// - The individual target address comes from six strapping pins, so 64 values can be selected.
// - The lowest bit of the address byte gives the direction: one means read, zero means write.
// - The broadcast address resets to E0h and is enabled, so E0h and E1h are acknowledged.
// - The three group addresses reset to E2h, E4h and E8h.
// - All group addresses start disabled, and a disabled group address is not acknowledged.
// - The broadcast and group addresses are written over the bus, held in flops, and reset to their defaults.
// - The general call address is acknowledged only with the direction bit at zero.
// - A software reset acts like power-on reset: all registers go to default and the LED outputs go low.
// - Reserved addresses picked by the straps are decoded and acknowledged like any other address.
// - After an address other than general call is acknowledged in a write, the next byte is stored as the register pointer.
// - An active-low enable input gates all sixteen LED outputs.
package lpad_pkg;
  localparam logic [7:0] PTR_MODE = 8'h00;
  localparam logic [7:0] PTR_GRP1 = 8'h02;
  localparam logic [7:0] PTR_GRP2 = 8'h03;
  localparam logic [7:0] PTR_GRP3 = 8'h04;
  localparam logic [7:0] PTR_BCAST = 8'h05;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] BCAST_DEFAULT = 8'hE0;
  localparam logic [7:0] GRP1_DEFAULT = 8'hE2;
  localparam logic [7:0] GRP2_DEFAULT = 8'hE4;
  localparam logic [7:0] GRP3_DEFAULT = 8'hE8;
  localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
  localparam logic [7:0] GC_RESET_BYTE = 8'h06;
  localparam logic STRAP_MSB = 1'b1;
  localparam int EN_BCAST_BIT = 0;
  localparam int EN_GRP3_BIT = 1;
  localparam int EN_GRP2_BIT = 2;
  localparam int EN_GRP1_BIT = 3;
  localparam logic [3:0] EN_DEFAULT = 4'h1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] TX_LAST_BIT = 4'h7;
  localparam logic [3:0] TXACK_SEEN = 4'h1;
  localparam int LED_COUNT = 16;
  localparam int STRAP_COUNT = 6;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} lpad_state_type;
  typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA, PH_GC} lpad_phase_type;
endpackage

//--- src/lpad_sync.sv
`timescale 1ns/1ns
module lpad_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  lpad_sync_if.filt port
);
  logic [W-1:0] s1_q, s2_q, s3_q, clean_q;
  logic [W-1:0] clean_d;

  // change only counts once the second and third stages agree
  always_comb begin
    clean_d = clean_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        clean_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      clean_q <= INIT;
    end else begin
      s1_q <= port.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= clean_d;
    end
  end

  assign port.clean = clean_q;
endmodule

//--- src/lpad_sync_if.sv
`timescale 1ns/1ns
interface lpad_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport filt(input raw, output clean);
  modport user(output raw, input clean);
endinterface

//--- src/lpad_top.sv
`timescale 1ns/1ns
module lpad_top (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic STRAP_ADDR_BIT_0,
  input wire logic STRAP_ADDR_BIT_1,
  input wire logic STRAP_ADDR_BIT_2,
  input wire logic STRAP_ADDR_BIT_3,
  input wire logic STRAP_ADDR_BIT_4,
  input wire logic STRAP_ADDR_BIT_5,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic AUTO_INC,
  input wire logic [15:0] LED_LEVEL,
  input wire logic [7:0] RD_DATA,
  output logic [15:0] PWM_OUTPUT_N,
  output logic [7:0] REG_PTR,
  output logic [7:0] WR_ADDR,
  output logic [7:0] WR_DATA,
  output logic WR_STROBE,
  output logic SOFT_RESET
);
  // ************************************************
  // input synchronisers
  // ************************************************
  lpad_sync_if #(.W(2)) bus_if ();
  lpad_sync_if #(.W(lpad_pkg::STRAP_COUNT)) strap_if ();
  lpad_sync_if #(.W(1)) oe_if ();

  assign bus_if.raw = {SCL, SDA_IN};
  assign strap_if.raw = {STRAP_ADDR_BIT_5, STRAP_ADDR_BIT_4, STRAP_ADDR_BIT_3,
                         STRAP_ADDR_BIT_2, STRAP_ADDR_BIT_1, STRAP_ADDR_BIT_0};
  assign oe_if.raw = OUTPUT_ENABLE_N;
  // idle bus is high, so start both lines high to avoid a false start
  lpad_sync #(.W(2), .INIT(2'h3)) u_sync_bus (
    .clk(CLOCK), .rst_n(RSTN), .port(bus_if));
  lpad_sync #(.W(lpad_pkg::STRAP_COUNT), .INIT(6'h00)) u_sync_strap (
    .clk(CLOCK), .rst_n(RSTN), .port(strap_if));
  lpad_sync #(.W(1), .INIT(1'h1)) u_sync_oe (
    .clk(CLOCK), .rst_n(RSTN), .port(oe_if));
  logic scl, sda;
  assign {scl, sda} = bus_if.clean;

  // ************************************************
  // state
  // ************************************************
  lpad_pkg::lpad_state_type state_q, state_d;
  lpad_pkg::lpad_phase_type phase_q, phase_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic sda_oe_q, sda_oe_d;
  logic [7:0] ptr_q, ptr_d, bcast_q, bcast_d;
  logic [7:0] grp1_q, grp1_d, grp2_q, grp2_d, grp3_q, grp3_d;
  logic [3:0] en_q, en_d;
  logic [15:0] led_q, led_d;
  logic [7:0] wr_addr_q, wr_addr_d, wr_data_q, wr_data_d;
  logic wr_strobe_q, wr_strobe_d, soft_q, soft_d;
  logic scl_prev_q, sda_prev_q, sda_out_q;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise = scl & ~scl_prev_q;
  assign scl_fall = ~scl & scl_prev_q;
  assign start_cond = scl & scl_prev_q & sda_prev_q & ~sda;
  assign stop_cond = scl & scl_prev_q & ~sda_prev_q & sda;

  logic [6:0] own_addr;
  logic own_hit, bcast_hit, grp_hit, gc_hit, addr_hit;
  assign own_addr = {lpad_pkg::STRAP_MSB, strap_if.clean};
  assign own_hit = sh_q[7:1] == own_addr;
  assign bcast_hit = en_q[lpad_pkg::EN_BCAST_BIT] && sh_q[7:1] == bcast_q[7:1];
  assign grp_hit = (en_q[lpad_pkg::EN_GRP1_BIT] && sh_q[7:1] == grp1_q[7:1])
                || (en_q[lpad_pkg::EN_GRP2_BIT] && sh_q[7:1] == grp2_q[7:1])
                || (en_q[lpad_pkg::EN_GRP3_BIT] && sh_q[7:1] == grp3_q[7:1]);
  assign gc_hit = sh_q == lpad_pkg::GC_ADDR_BYTE;
  assign addr_hit = own_hit | bcast_hit | grp_hit | gc_hit;

  logic [7:0] rd_byte, ptr_inc;
  always_comb begin
    case (ptr_q)
      lpad_pkg::PTR_MODE: rd_byte = {4'h0, en_q};
      lpad_pkg::PTR_GRP1: rd_byte = grp1_q;
      lpad_pkg::PTR_GRP2: rd_byte = grp2_q;
      lpad_pkg::PTR_GRP3: rd_byte = grp3_q;
      lpad_pkg::PTR_BCAST: rd_byte = bcast_q;
      default: rd_byte = RD_DATA;
    endcase
  end

  assign ptr_inc = AUTO_INC ? ptr_q + 8'h01 : ptr_q;

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    sda_oe_d = sda_oe_q;
    ptr_d = ptr_q;
    bcast_d = bcast_q;
    grp1_d = grp1_q;
    grp2_d = grp2_q;
    grp3_d = grp3_q;
    en_d = en_q;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    wr_strobe_d = 1'b0;
    soft_d = 1'b0;
    led_d = oe_if.clean[0] ? 16'h0000 : LED_LEVEL;
    if (stop_cond) begin
      state_d = lpad_pkg::ST_IDLE;
      sda_oe_d = 1'b0;
    end else if (start_cond) begin
      state_d = lpad_pkg::ST_RX;
      phase_d = lpad_pkg::PH_ADDR;
      cnt_d = 4'h0;
      sda_oe_d = 1'b0;
    end else begin
      case (state_q)
        lpad_pkg::ST_RX: begin
          if (scl_rise && cnt_q != lpad_pkg::BITS_PER_BYTE) begin
            sh_d = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == lpad_pkg::BITS_PER_BYTE) begin
            cnt_d = 4'h0;
            state_d = lpad_pkg::ST_IDLE;
            case (phase_q)
              lpad_pkg::PH_ADDR: begin
                if (addr_hit) begin
                  state_d = lpad_pkg::ST_ACK;
                  sda_oe_d = 1'b1;
                end
              end
              lpad_pkg::PH_PTR: begin
                ptr_d = sh_q;
                state_d = lpad_pkg::ST_ACK;
                sda_oe_d = 1'b1;
              end
              lpad_pkg::PH_DATA: begin
                state_d = lpad_pkg::ST_ACK;
                sda_oe_d = 1'b1;
                wr_strobe_d = 1'b1;
                wr_addr_d = ptr_q;
                wr_data_d = sh_q;
                ptr_d = ptr_inc;
                case (ptr_q)
                  lpad_pkg::PTR_MODE: en_d = sh_q[3:0];
                  lpad_pkg::PTR_GRP1: grp1_d = sh_q;
                  lpad_pkg::PTR_GRP2: grp2_d = sh_q;
                  lpad_pkg::PTR_GRP3: grp3_d = sh_q;
                  lpad_pkg::PTR_BCAST: bcast_d = sh_q;
                  default: ;
                endcase
              end
              lpad_pkg::PH_GC: begin
                if (sh_q == lpad_pkg::GC_RESET_BYTE) begin
                  state_d = lpad_pkg::ST_ACK;
                  sda_oe_d = 1'b1;
                  soft_d = 1'b1;
                  ptr_d = lpad_pkg::PTR_RESET;
                  bcast_d = lpad_pkg::BCAST_DEFAULT;
                  grp1_d = lpad_pkg::GRP1_DEFAULT;
                  grp2_d = lpad_pkg::GRP2_DEFAULT;
                  grp3_d = lpad_pkg::GRP3_DEFAULT;
                  en_d = lpad_pkg::EN_DEFAULT;
                  led_d = 16'h0000;
                end
              end
              default: ;
            endcase
          end
        end
        lpad_pkg::ST_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            state_d = lpad_pkg::ST_RX;
            cnt_d = 4'h0;
            case (phase_q)
              lpad_pkg::PH_ADDR: begin
                if (gc_hit) begin
                  phase_d = lpad_pkg::PH_GC;
                end else if (sh_q[0]) begin
                  state_d = lpad_pkg::ST_TX;
                  sh_d = rd_byte;
                  sda_oe_d = ~rd_byte[7];
                end else begin
                  phase_d = lpad_pkg::PH_PTR;
                end
              end
              lpad_pkg::PH_PTR: phase_d = lpad_pkg::PH_DATA;
              lpad_pkg::PH_DATA: phase_d = lpad_pkg::PH_DATA;
              default: state_d = lpad_pkg::ST_IDLE;
            endcase
          end
        end
        lpad_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == lpad_pkg::TX_LAST_BIT) begin
              sda_oe_d = 1'b0;
              cnt_d = 4'h0;
              state_d = lpad_pkg::ST_TXACK;
            end else begin
              cnt_d = cnt_q + 4'h1;
              sh_d = {sh_q[6:0], 1'b0};
              sda_oe_d = ~sh_q[6];
            end
          end
        end
        lpad_pkg::ST_TXACK: begin
          if (scl_rise) begin
            if (sda) begin
              state_d = lpad_pkg::ST_IDLE;
            end else begin
              ptr_d = ptr_inc;
              cnt_d = lpad_pkg::TXACK_SEEN;
            end
          end else if (scl_fall && cnt_q == lpad_pkg::TXACK_SEEN) begin
            state_d = lpad_pkg::ST_TX;
            cnt_d = 4'h0;
            sh_d = rd_byte;
            sda_oe_d = ~rd_byte[7];
          end
        end
        default: ;
      endcase
    end
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= lpad_pkg::ST_IDLE;
      phase_q <= lpad_pkg::PH_ADDR;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      sda_oe_q <= 1'b0;
      ptr_q <= lpad_pkg::PTR_RESET;
      bcast_q <= lpad_pkg::BCAST_DEFAULT;
      grp1_q <= lpad_pkg::GRP1_DEFAULT;
      grp2_q <= lpad_pkg::GRP2_DEFAULT;
      grp3_q <= lpad_pkg::GRP3_DEFAULT;
      en_q <= lpad_pkg::EN_DEFAULT;
      led_q <= 16'h0000;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      wr_strobe_q <= 1'b0;
      soft_q <= 1'b0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      sda_out_q <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      sda_oe_q <= sda_oe_d;
      ptr_q <= ptr_d;
      bcast_q <= bcast_d;
      grp1_q <= grp1_d;
      grp2_q <= grp2_d;
      grp3_q <= grp3_d;
      en_q <= en_d;
      led_q <= led_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      wr_strobe_q <= wr_strobe_d;
      soft_q <= soft_d;
      scl_prev_q <= scl;
      sda_prev_q <= sda;
      sda_out_q <= 1'b0;
    end
  end

  // open drain: the data flop stays low, only the enable moves
  assign SDA_OUT = sda_out_q;
  assign SDA_OE = sda_oe_q;
  assign PWM_OUTPUT_N = led_q;
  assign REG_PTR = ptr_q;
  assign WR_ADDR = wr_addr_q;
  assign WR_DATA = wr_data_q;
  assign WR_STROBE = wr_strobe_q;
  assign SOFT_RESET = soft_q;
endmodule
